// [capture_channel.sv]
// One 16-bit capture channel with edge prescale and hold-until-read.
// Assumes the register bus reports byte reads as one-cycle strobes.
`default_nettype none

module capture_channel
  import dual_timer_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Capture pin and mode
  input  wire logic        pin,
  input  wire logic [1:0]  edge_mode,
  input  wire logic        enable,
  input  wire logic [15:0] time_base,
  // Software access
  input  wire logic        rd_low,
  input  wire logic        rd_high,
  input  wire logic        wr_low,
  input  wire logic        wr_high,
  input  wire logic [7:0]  wdata,
  // Captured value and status
  output logic [15:0]      value,
  output logic             ovf
);

  logic       rise;
  logic       fall;
  logic [3:0] rise_count;
  logic       full;
  logic       low_seen;
  logic       high_seen;
  logic       event_hit;
  logic       release_now;

  pin_edge_sync u_sync
  (
    .clk  (clk),
    .rst  (rst),
    .pin  (pin),
    .rise (rise),
    .fall (fall)
  );

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rise_count <= 4'h0;
    else if (rise)
      rise_count <= rise_count + 4'h1;
  end

  always_comb
  begin
    unique case (edge_mode_t'(edge_mode)) // R7
      EDGE_FALL:   event_hit = fall;
      EDGE_RISE:   event_hit = rise;
      EDGE_RISE4:  event_hit = rise && (rise_count[1:0] == RISE4_LAST[1:0]);
      EDGE_RISE16: event_hit = rise && (rise_count == RISE16_LAST);
    endcase
  end

  // Both bytes must have been read before the hold is released
  assign release_now = full && (rd_low || rd_high) // R12
                       && (rd_low || low_seen) && (rd_high || high_seen);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      full      <= 1'b0;
      ovf       <= 1'b0;
      low_seen  <= 1'b0;
      high_seen <= 1'b0;
    end
    else if (!enable)
    begin
      full      <= 1'b0;
      ovf       <= 1'b0;
      low_seen  <= 1'b0;
      high_seen <= 1'b0;
    end
    else if (event_hit && full && !release_now)
    begin
      ovf       <= 1'b1; // R11
      low_seen  <= low_seen | rd_low;
      high_seen <= high_seen | rd_high;
    end
    else if (event_hit)
    begin
      full      <= 1'b1;
      ovf       <= 1'b0;
      low_seen  <= 1'b0;
      high_seen <= 1'b0;
    end
    else if (release_now)
    begin
      full      <= 1'b0;
      ovf       <= 1'b0;
      low_seen  <= 1'b0;
      high_seen <= 1'b0;
    end
    else
    begin
      low_seen  <= low_seen | (full & rd_low);
      high_seen <= high_seen | (full & rd_high);
    end
  end

  // Value loads only when not holding an unread capture
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      value <= 16'h0000;
    else if (enable && event_hit && (!full || release_now))
      value <= time_base; // R4 R12
    else if (!enable && wr_low)
      value[7:0] <= wdata;
    else if (!enable && wr_high)
      value[15:8] <= wdata;
  end

endmodule

`default_nettype wire

// [dual_timer_capture_control.sv]
// Two 8-bit period timers, a 16-bit capture time base, four captures
// and PWM pin direction takeover, behind an Avalon-MM slave.
// Assumes all pins are sampled into the single clk domain.
`default_nettype none

// Summary of operation
// R1: Two independent 8-bit timers with periods and flags
// R2: Timers count instruction clock or external falling edge
// R3: timer_c is 16-bit, internal or external clocked
// R4: timer_c value loads all four capture pairs
// R5: Mode bit picks period or first capture
// R6: PWMs use timer_a/b, captures use timer_c
// R7: Edge mode: fall, rise, fourth, sixteenth rise
// R8: Capture edge fields at control-one bits 7-4
// R9: Pair select joins timer_b and timer_a
// R10: Source bits choose external pin or internal
// R11: Overflow flag on capture before pair read
// R12: Held pair keeps oldest value until read
// R13: PWM enable overrides pin direction bit
// R14: timer_c run bit starts and stops it
// R15: Software keeps timer_b run set when paired
// R16: timer_a run gates paired or single timer
// R17: 8-bit timers wrap after period, set flag
// R18: Paired timer wraps after 16-bit period, flags
// R19: timer_c rolling to zero sets its flag
// R20: Stopped timers neither count nor set flags
// R21: External pins synchronised before edge detection
// R22: Without period timer_c wraps FFFFh to zero
module dual_timer_capture_control
  import dual_timer_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Avalon-MM slave
  input  wire dual_timer_pkg::avmm_req_t avs_req,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  // External count and capture pins
  input  wire logic                   ext_clk_ab,
  input  wire logic                   ext_clk_c,
  input  wire logic [3:0]             cap_pin,
  // PWM pins; duty is generated elsewhere from the timer values
  input  wire logic                   pwm1_level,
  input  wire logic                   pwm2_level,
  input  wire logic [1:0]             port_pin_data,
  output logic                        pwm_out_one_pin_o,
  output logic                        pwm_out_one_pin_oe_n,
  output logic                        pwm_out_two_pin_o,
  output logic                        pwm_out_two_pin_oe_n,
  // Time bases and flags
  output logic [7:0]                  timer_a_value,
  output logic [7:0]                  timer_b_value,
  output logic [15:0]                 timer_c_value,
  output logic                        timer_a_irq_flag,
  output logic                        timer_b_irq_flag,
  output logic                        timer_c_irq_flag
);

  ctl1_t       ctl1;
  ctl2_t       ctl2;
  cap34_t      cap34;
  logic [7:0]  timer_a;
  logic [7:0]  timer_b;
  logic [15:0] timer_c;
  logic [7:0]  period_a;
  logic [7:0]  period_b;
  logic [7:0]  port_direction_reg;
  logic [1:0]  div_count;
  logic        instr_tick;
  logic        ab_fall;
  logic        c_fall;
  logic        inc_a;
  logic        inc_b;
  logic        inc_c;
  logic        rd_ack;
  logic        rd_fire;
  logic        wr_fire;
  logic [5:0]  idx;
  logic [7:0]  wbyte;
  logic [15:0] cap_value [4];
  logic [3:0]  cap_ovf;
  logic [3:0]  cap_enable;
  logic [1:0]  cap_mode [4];
  logic [7:0]  next_readdata;

  // Bus decode: writes take effect at once, reads wait one cycle
  assign idx     = avs_req.address[7:2];
  assign wbyte   = avs_req.writedata[7:0];
  assign wr_fire = avs_req.write && avs_req.byteenable[0];
  assign rd_fire = avs_req.read && rd_ack;
  assign avs_waitrequest = avs_req.read && !rd_ack;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rd_ack <= 1'b0;
    else
      rd_ack <= avs_req.read && !rd_ack;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_req.read && !rd_ack)
      avs_readdata <= {24'h00_0000, next_readdata};
  end

  // Instruction clock is one clk in four
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      div_count <= 2'h0;
    else if (div_count == 2'(INSTR_DIV - 1))
      div_count <= 2'h0;
    else
      div_count <= div_count + 2'h1;
  end

  assign instr_tick = (div_count == 2'(INSTR_DIV - 1));

  pin_edge_sync u_sync_ab
  (
    .clk  (clk),
    .rst  (rst),
    .pin  (ext_clk_ab),
    .rise (),
    .fall (ab_fall)
  );

  pin_edge_sync u_sync_c
  (
    .clk  (clk),
    .rst  (rst),
    .pin  (ext_clk_c),
    .rise (),
    .fall (c_fall)
  );

  // Paired mode takes both halves from the timer_a source select
  assign inc_a = ctl1.timer_a_src_sel ? ab_fall : instr_tick; // R2 R10
  assign inc_b = (ctl1.timer_b_src_sel ? ab_fall : instr_tick) // R2 R10
                 && !ctl1.pair_16bit_sel;
  assign inc_c = ctl1.timer_c_src_sel ? c_fall : instr_tick; // R3 R10

  // Control and setup registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctl1               <= ctl1_t'(CTL1_RESET);
      ctl2               <= ctl2_t'(CTL2_RESET);
      cap34              <= cap34_t'(CAP34_RESET);
      period_a           <= PERIOD_RESET;
      period_b           <= PERIOD_RESET;
      port_direction_reg <= PORT_DIR_RESET;
    end
    else if (wr_fire)
    begin
      unique case (idx)
        IDX_CTL1:     ctl1 <= ctl1_t'(wbyte); // R8 R9 R10
        IDX_CTL2:     ctl2[5:0] <= wbyte[5:0];
        IDX_CAP34_CTL: cap34[4:0] <= wbyte[4:0];
        IDX_PERIOD_A: period_a <= wbyte;
        IDX_PERIOD_B: period_b <= wbyte;
        IDX_PORT_DIR: port_direction_reg <= wbyte;
        default:      ctl2[5:0] <= ctl2[5:0];
      endcase
    end
  end

  // timer_a and timer_b, separate or joined
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      timer_a <= 8'h00;
      timer_b <= 8'h00;
    end
    else if (wr_fire && idx == IDX_TIMER_A)
      timer_a <= wbyte;
    else if (wr_fire && idx == IDX_TIMER_B)
      timer_b <= wbyte;
    else if (ctl1.pair_16bit_sel)
    begin
      if (ctl2.timer_a_run && inc_a) // R16 R20
      begin
        if ({timer_b, timer_a} == {period_b, period_a})
        begin
          timer_a <= 8'h00; // R18
          timer_b <= 8'h00;
        end
        else
        begin
          timer_a <= timer_a + 8'h01;
          if (timer_a == 8'hff && ctl2.timer_b_run) // R15 R9
            timer_b <= timer_b + 8'h01;
        end
      end
    end
    else
    begin
      if (ctl2.timer_a_run && inc_a) // R1 R20
        timer_a <= (timer_a == period_a) ? 8'h00 : timer_a + 8'h01; // R17
      if (ctl2.timer_b_run && inc_b) // R1 R20
        timer_b <= (timer_b == period_b) ? 8'h00 : timer_b + 8'h01; // R17
    end
  end

  // timer_c with optional period
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      timer_c <= 16'h0000;
    else if (wr_fire && idx == IDX_TIMER_C_LOW)
      timer_c[7:0] <= wbyte;
    else if (wr_fire && idx == IDX_TIMER_C_HIGH)
      timer_c[15:8] <= wbyte;
    else if (ctl2.timer_c_run && inc_c) // R14 R20
    begin
      if (!ctl2.cap_or_period_sel && timer_c == cap_value[0]) // R5
        timer_c <= 16'h0000;
      else
        timer_c <= timer_c + 16'h0001; // R22
    end
  end

  // Flags: hardware set wins over write-one-to-clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      timer_a_irq_flag <= 1'b0;
      timer_b_irq_flag <= 1'b0;
      timer_c_irq_flag <= 1'b0;
    end
    else
    begin
      if (ctl2.timer_a_run && inc_a && (ctl1.pair_16bit_sel // R20
          ? {timer_b, timer_a} == {period_b, period_a} // R18
          : timer_a == period_a)) // R17
        timer_a_irq_flag <= 1'b1;
      else if (wr_fire && idx == IDX_IRQ_FLAGS && wbyte[IRQ_A_BIT])
        timer_a_irq_flag <= 1'b0;
      if (ctl2.timer_b_run && inc_b && timer_b == period_b) // R17 R20
        timer_b_irq_flag <= 1'b1;
      else if (wr_fire && idx == IDX_IRQ_FLAGS && wbyte[IRQ_B_BIT])
        timer_b_irq_flag <= 1'b0;
      if (ctl2.timer_c_run && inc_c && ((!ctl2.cap_or_period_sel // R19
          && timer_c == cap_value[0]) || timer_c == 16'hffff))
        timer_c_irq_flag <= 1'b1;
      else if (wr_fire && idx == IDX_IRQ_FLAGS && wbyte[IRQ_C_BIT])
        timer_c_irq_flag <= 1'b0;
    end
  end

  // Four captures on the timer_c time base
  assign cap_enable  = {3'b111, ctl2.cap_or_period_sel}; // R5
  assign cap_mode[0] = ctl1.cap1_edge_mode; // R8
  assign cap_mode[1] = ctl1.cap2_edge_mode; // R8
  assign cap_mode[2] = cap34.cap3_edge_mode;
  assign cap_mode[3] = cap34.cap4_edge_mode;

  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_cap
      localparam logic [5:0] LOW_IDX  = IDX_CAP_BASE + 6'(2 * i);
      localparam logic [5:0] HIGH_IDX = IDX_CAP_BASE + 6'(2 * i + 1);

      capture_channel u_cap
      (
        .clk       (clk),
        .rst       (rst),
        .pin       (cap_pin[i]),
        .edge_mode (cap_mode[i]),
        .enable    (cap_enable[i]),
        .time_base (timer_c), // R4 R6
        .rd_low    (rd_fire && idx == LOW_IDX),
        .rd_high   (rd_fire && idx == HIGH_IDX),
        .wr_low    (wr_fire && idx == LOW_IDX && i == 0),
        .wr_high   (wr_fire && idx == HIGH_IDX && i == 0),
        .wdata     (wbyte),
        .value     (cap_value[i]),
        .ovf       (cap_ovf[i])
      );
    end
  endgenerate

  // Status view of overflow bits is read-only
  always_comb
  begin
    next_readdata = 8'h00;
    unique case (idx)
      IDX_TIMER_A:      next_readdata = timer_a;
      IDX_TIMER_B:      next_readdata = timer_b;
      IDX_TIMER_C_LOW:  next_readdata = timer_c[7:0];
      IDX_TIMER_C_HIGH: next_readdata = timer_c[15:8];
      IDX_PERIOD_A:     next_readdata = period_a;
      IDX_PERIOD_B:     next_readdata = period_b;
      IDX_CTL1:         next_readdata = ctl1;
      IDX_CTL2:         next_readdata = {cap_ovf[1], cap_ovf[0], // R11
                                         ctl2[5:0]};
      IDX_CAP34_CTL:    next_readdata = {1'b0, cap_ovf[3], cap_ovf[2],
                                         cap34[4:0]};
      IDX_IRQ_FLAGS:    next_readdata = {5'h00, timer_c_irq_flag,
                                         timer_b_irq_flag, timer_a_irq_flag};
      IDX_PORT_DIR:     next_readdata = port_direction_reg;
      default:
      begin
        for (int k = 0; k < 4; k++)
        begin
          if (idx == IDX_CAP_BASE + 6'(2 * k))
            next_readdata = cap_value[k][7:0];
          if (idx == IDX_CAP_BASE + 6'(2 * k + 1))
            next_readdata = cap_value[k][15:8];
        end
      end
    endcase
  end

  // Unused struct bits kept at zero in storage view
  assign timer_a_value = timer_a; // R6
  assign timer_b_value = timer_b; // R6
  assign timer_c_value = timer_c;

  // Direction bit high means input; enable overrides it
  assign pwm_out_one_pin_oe_n = ctl2.pwm1_en ? 1'b0 // R13
                                : port_direction_reg[PWM1_DIR_BIT];
  assign pwm_out_two_pin_oe_n = ctl2.pwm2_en ? 1'b0 // R13
                                : port_direction_reg[PWM2_DIR_BIT];
  assign pwm_out_one_pin_o = ctl2.pwm1_en ? pwm1_level : port_pin_data[0];
  assign pwm_out_two_pin_o = ctl2.pwm2_en ? pwm2_level : port_pin_data[1];

endmodule

`default_nettype wire

// [dual_timer_pkg.sv]
// Shared constants, register map and carrier types for the dual timer
// and capture block. Assumes a single 10 MHz system clock domain.
`default_nettype none

package dual_timer_pkg;

  // Clock and instruction rate
  localparam int CLK_HZ        = 10_000_000;
  localparam int OSC_PER_INSTR = 4;
  localparam int INSTR_HZ      = CLK_HZ / OSC_PER_INSTR;
  localparam int INSTR_DIV     = CLK_HZ / INSTR_HZ;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_TIMER_A       = 6'h10;
  localparam logic [5:0] IDX_TIMER_B       = 6'h11;
  localparam logic [5:0] IDX_TIMER_C_LOW   = 6'h12;
  localparam logic [5:0] IDX_TIMER_C_HIGH  = 6'h13;
  localparam logic [5:0] IDX_PERIOD_A      = 6'h14;
  localparam logic [5:0] IDX_PERIOD_B      = 6'h15;
  localparam logic [5:0] IDX_CTL1          = 6'h16;
  localparam logic [5:0] IDX_CTL2          = 6'h17;
  localparam logic [5:0] IDX_CAP34_CTL     = 6'h18;
  localparam logic [5:0] IDX_IRQ_FLAGS     = 6'h19;
  localparam logic [5:0] IDX_PORT_DIR      = 6'h1a;
  localparam logic [5:0] IDX_CAP_BASE      = 6'h1b;

  // Reset values
  localparam logic [7:0] CTL1_RESET        = 8'h00;
  localparam logic [7:0] CTL2_RESET        = 8'h00;
  localparam logic [7:0] CAP34_RESET       = 8'h00;
  localparam logic [7:0] PERIOD_RESET      = 8'hff;
  localparam logic [7:0] PORT_DIR_RESET    = 8'hff;

  // Field positions
  localparam int IRQ_A_BIT    = 0;
  localparam int IRQ_B_BIT    = 1;
  localparam int IRQ_C_BIT    = 2;
  localparam int PWM1_DIR_BIT = 2;
  localparam int PWM2_DIR_BIT = 3;

  // Edge prescale terminal counts
  localparam logic [3:0] RISE4_LAST  = 4'h3;
  localparam logic [3:0] RISE16_LAST = 4'hf;

  typedef enum logic [1:0] {
    EDGE_FALL   = 2'b00,
    EDGE_RISE   = 2'b01,
    EDGE_RISE4  = 2'b10,
    EDGE_RISE16 = 2'b11
  } edge_mode_t;

  typedef struct packed {
    logic       read;
    logic       write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avmm_req_t;

  typedef struct packed {
    logic [1:0] cap2_edge_mode;
    logic [1:0] cap1_edge_mode;
    logic       pair_16bit_sel;
    logic       timer_c_src_sel;
    logic       timer_b_src_sel;
    logic       timer_a_src_sel;
  } ctl1_t;

  typedef struct packed {
    logic cap2_ovf;
    logic cap1_ovf;
    logic pwm2_en;
    logic pwm1_en;
    logic cap_or_period_sel;
    logic timer_c_run;
    logic timer_b_run;
    logic timer_a_run;
  } ctl2_t;

  typedef struct packed {
    logic       unused;
    logic       cap4_ovf;
    logic       cap3_ovf;
    logic [1:0] cap4_edge_mode;
    logic [1:0] cap3_edge_mode;
    logic       pwm3_en;
  } cap34_t;

endpackage

`default_nettype wire

// [dual_timer_sva.sv]
// Assertions on the dual timer block's top-level ports.
// Assumes counters are written only while stopped.
`default_nettype none
module dual_timer_sva
  import dual_timer_pkg::*;
(
  // Clock and reset
  input wire logic                      clk,
  input wire logic                      rst,
  // Register bus
  input wire dual_timer_pkg::avmm_req_t avs_req,
  input wire logic [31:0]               avs_readdata,
  input wire logic                      avs_waitrequest,
  // Pins, counters and flags
  input wire logic                      pwm1_level,
  input wire logic                      pwm_out_one_pin_o,
  input wire logic                      pwm_out_one_pin_oe_n,
  input wire logic                      pwm_out_two_pin_oe_n,
  input wire logic [7:0]                timer_a_value,
  input wire logic [7:0]                timer_b_value,
  input wire logic [15:0]               timer_c_value,
  input wire logic                      timer_a_irq_flag,
  input wire logic                      timer_b_irq_flag,
  input wire logic                      timer_c_irq_flag
);
  // Shadows follow taken writes
  logic [7:0] sh1, sh2, dir;
  logic [5:0] ix;
  logic       we, rd_ok, wr_a, wr_b, wr_c;
  assign ix    = avs_req.address[7:2];
  assign we    = avs_req.write && !avs_waitrequest && avs_req.byteenable[0];
  assign rd_ok = avs_req.read && !avs_waitrequest;
  assign wr_a  = we && ix == IDX_TIMER_A;
  assign wr_b  = we && ix == IDX_TIMER_B;
  assign wr_c  = we && ix[5:1] == 5'h09;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      sh1 <= CTL1_RESET;
      sh2 <= CTL2_RESET;
      dir <= PORT_DIR_RESET;
    end
    else if (we)
    begin
      if (ix == IDX_CTL1)
        sh1 <= avs_req.writedata[7:0];
      if (ix == IDX_CTL2)
        sh2 <= avs_req.writedata[7:0];
      if (ix == IDX_PORT_DIR)
        dir <= avs_req.writedata[7:0];
    end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ctl1_read_a: assert property (
    rd_ok && ix == IDX_CTL1 |-> avs_readdata[7:0] == sh1)
    else $error("ctl1 readback");
  ctl2_read_a: assert property (
    rd_ok && ix == IDX_CTL2 |-> avs_readdata[5:0] == sh2[5:0])
    else $error("ctl2 readback");
  flag_a_zero_a: assert property (
    $rose(timer_a_irq_flag) |-> timer_a_value == 8'h00)
    else $error("a flag no wrap");
  flag_c_zero_a: assert property (
    $rose(timer_c_irq_flag) |-> timer_c_value == 16'h0000)
    else $error("c flag no wrap");
  c_step_a: assert property (
    $changed(timer_c_value) && !$past(wr_c)
    |-> timer_c_value == $past(timer_c_value) + 16'h1 || timer_c_value == 0)
    else $error("c bad step");
  c_stop_a: assert property (
    !sh2[2] && !wr_c |=> $stable(timer_c_value))
    else $error("c runs stopped");
  a_stop_a: assert property (
    !sh2[0] && !wr_a |=> $stable(timer_a_value) && !$rose(timer_a_irq_flag))
    else $error("a runs stopped");
  b_stop_a: assert property (
    !sh2[1] && !wr_b |=> $stable(timer_b_value) && !$rose(timer_b_irq_flag))
    else $error("b runs stopped");
  tick_space_a: assert property (
    $changed(timer_a_value) && !sh1[0] && !$past(wr_a)
    |=> $stable(timer_a_value) [*3])
    else $error("tick too soon");
  pwm_dir_a: assert property (
    {pwm_out_two_pin_oe_n, pwm_out_one_pin_oe_n} == (~sh2[5:4] & dir[3:2]))
    else $error("pin enable wrong");
  pwm_data_a: assert property (
    sh2[4] |-> pwm_out_one_pin_o == pwm1_level)
    else $error("pwm level lost");
endmodule
`default_nettype wire

// [ext_pins.sv]
// Pin model: count pins and four capture pins.
// Assumes pull-ups: lines idle high.
`default_nettype none
module ext_pins
(
  // Clock
  input  wire logic  clk,
  // 0 ab count, 1 c count, 5:2 captures
  output logic [5:0] line
);
  initial line = 6'h3f;
  // Under one clock a pulse may be missed
  task automatic pulse(input int n, input int w);
    line[n] <= 1'b0;
    repeat (w) @(posedge clk);
    line[n] <= 1'b1;
    repeat (w) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [pin_edge_sync.sv]
// Two-flop synchroniser with rise and fall pulse detection.
// Assumes the pin may change at any time relative to clk.
`default_nettype none

module pin_edge_sync
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Pin and edge pulses
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);

  logic meta;
  logic stable;
  logic last;

  // First flop feeds only the second, so no edge logic sees metastability
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // Idle-high reset avoids a false edge at release
      meta   <= 1'b1;
      stable <= 1'b1;
      last   <= 1'b1;
    end
    else
    begin
      meta   <= pin;
      stable <= meta;
      last   <= stable;
    end
  end

  assign rise = stable & ~last; // R21
  assign fall = ~stable & last; // R21

endmodule

`default_nettype wire

// [test_dual_timer_capture_control.sv]
// Random and corner tests of the dual timer block.
// Assumes package, checker and pin model compile first.
`default_nettype none
module test_dual_timer_capture_control;
  timeunit 1ns;
  timeprecision 1ns;
  import dual_timer_pkg::*;
  logic        clk, rst, pwm1_level, pwm2_level, fa, fb, fc;
  logic        wait_rq, o1, o2, oe1_n, oe2_n;
  logic [1:0]  port_data;
  logic [5:0]  line;
  logic [7:0]  ta, tb_v, v8;
  logic [15:0] tc, v, prev, t0;
  logic [31:0] rdata, seed;
  avmm_req_t   req;
  int          bad_count, n_checks, hits;
  int          np[4] = '{4, 4, 8, 16};
  int          nh[4] = '{4, 4, 2, 1};

  dual_timer_capture_control dual_timer_capture_control_inst (
    .clk, .rst, .avs_req(req), .avs_readdata(rdata),
    .avs_waitrequest(wait_rq), .ext_clk_ab(line[0]), .ext_clk_c(line[1]),
    .cap_pin(line[5:2]), .pwm1_level, .pwm2_level,
    .port_pin_data(port_data), .pwm_out_one_pin_o(o1),
    .pwm_out_one_pin_oe_n(oe1_n), .pwm_out_two_pin_o(o2),
    .pwm_out_two_pin_oe_n(oe2_n), .timer_a_value(ta),
    .timer_b_value(tb_v), .timer_c_value(tc), .timer_a_irq_flag(fa),
    .timer_b_irq_flag(fb), .timer_c_irq_flag(fc));
  ext_pins ext_pins_inst (.clk, .line);

  always #50 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic stop_test;
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask

  // Hold request until waitrequest low
  task automatic wr(input logic [5:0] i, input logic [7:0] d,
                    input logic be = 1'b1);
    @(posedge clk);
    req <= '{1'b0, 1'b1, {i, 2'b00}, {24'h0, d}, {3'h0, be}};
    do @(posedge clk); while (wait_rq !== 1'b0);
    req <= '0;
  endtask

  task automatic rd(input logic [5:0] i, output logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, {i, 2'b00}, 32'h0, 4'h1};
    do @(posedge clk); while (wait_rq !== 1'b0);
    d = rdata[7:0];
    req <= '0;
  endtask

  task automatic rdc(input logic [5:0] i, input logic [7:0] exp);
    logic [7:0] d;
    rd(i, d);
    chk(d, exp);
  endtask

  // Low then high byte
  task automatic rdp(input int ch, output logic [15:0] d);
    rd(IDX_CAP_BASE + 6'(2 * ch - 2), d[7:0]);
    rd(IDX_CAP_BASE + 6'(2 * ch - 1), d[15:8]);
  endtask

  task automatic wait_flag(input int k, input int n);
    repeat (n)
      if (((({fc, fb, fa}) >> k) & 3'h1) !== 3'h1)
        @(posedge clk);
  endtask

  initial
  begin
    #3000000;
    bad_count++;
    stop_test;
  end

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    req = '0;
    seed = 32'd69573;
    pwm1_level = 1'b0;
    pwm2_level = 1'b0;
    port_data = 2'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdc(IDX_CTL1, 8'h00);
    rdc(IDX_CTL2, 8'h00);
    rdc(6'h3f, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      pwm1_level <= seed[24];
      pwm2_level <= seed[25];
      port_data <= seed[27:26];
      wr(IDX_CTL1, seed[7:0]);
      wr(IDX_CTL2, seed[15:8] & 8'h38);
      wr(IDX_PORT_DIR, seed[23:16]);
      rdc(IDX_CTL1, seed[7:0]);
      rdc(IDX_CTL2, seed[15:8] & 8'h38);
      chk(oe1_n, !seed[12] && seed[18]);
      chk(oe2_n, !seed[13] && seed[19]);
      chk(o1, seed[12] ? seed[24] : seed[26]);
      chk(o2, seed[13] ? seed[25] : seed[27]);
    end
    wr(IDX_CTL1, 8'h00);
    wr(IDX_CTL1, 8'hff, 1'b0);
    rdc(IDX_CTL1, 8'h00);
    wr(IDX_CTL2, 8'hc0);
    rdc(IDX_CTL2, 8'h00);
    // timer_a internal tick, then stopped
    wr(IDX_PERIOD_A, 8'h03);
    wr(IDX_TIMER_A, 8'h00);
    wr(IDX_CTL2, 8'h01);
    wait_flag(0, 40);
    chk(ta, 8'h00);
    chk({fb, fa}, 2'b01);
    wr(IDX_CTL2, 8'h00);
    wr(IDX_IRQ_FLAGS, 8'h07);
    rd(IDX_TIMER_A, v8);
    repeat (40) @(posedge clk);
    rdc(IDX_TIMER_A, v8);
    chk(fa, 1'b0);
    // timer_b on shared pin falls
    wr(IDX_CTL1, 8'h02);
    wr(IDX_PERIOD_B, 8'h02);
    wr(IDX_TIMER_B, 8'h00);
    wr(IDX_CTL2, 8'h02);
    for (int i = 0; i < 3; i++)
    begin
      chk(tb_v, 8'(i));
      ext_pins_inst.pulse(0, 3 + 6 * (i % 2));
    end
    chk({fb, tb_v}, 9'h100);
    // Paired: timer_b idle until run
    wr(IDX_CTL2, 8'h00);
    wr(IDX_IRQ_FLAGS, 8'h07);
    wr(IDX_CTL1, 8'h08);
    wr(IDX_PERIOD_A, 8'h02);
    wr(IDX_PERIOD_B, 8'h01);
    wr(IDX_TIMER_A, 8'h00);
    wr(IDX_TIMER_B, 8'h00);
    wr(IDX_CTL2, 8'h01);
    repeat (100) @(posedge clk);
    chk(tb_v, 8'h00);
    wr(IDX_CTL2, 8'h03);
    wait_flag(0, 1200);
    chk({fb, fa, tb_v, ta}, 18'h10000);
    // timer_c across FFFF, then period
    wr(IDX_CTL2, 8'h08);
    wr(IDX_CTL1, 8'h00);
    wr(IDX_IRQ_FLAGS, 8'h07);
    wr(IDX_TIMER_C_LOW, 8'hfe);
    wr(IDX_TIMER_C_HIGH, 8'hff);
    wr(IDX_CTL2, 8'h0c);
    wait_flag(2, 20);
    chk({fc, tc}, 17'h10000);
    wr(IDX_CTL2, 8'h00);
    wr(IDX_IRQ_FLAGS, 8'h07);
    wr(IDX_CAP_BASE, 8'h05);
    wr(IDX_CAP_BASE + 6'h1, 8'h00);
    rdc(IDX_CAP_BASE, 8'h05);
    wr(IDX_TIMER_C_LOW, 8'h00);
    wr(IDX_CTL2, 8'h04);
    wait_flag(2, 40);
    chk({fc, tc}, 17'h10000);
    // Edge modes on capture two
    wr(IDX_CTL2, 8'h0c);
    for (int m = 0; m < 4; m++)
    begin
      wr(IDX_CTL1, {2'(m), 6'h00});
      hits = 0;
      rdp(2, prev);
      for (int k = 0; k < np[m]; k++)
      begin
        ext_pins_inst.pulse(3, 3 + 6 * (k % 2));
        rdp(2, v);
        if (v !== prev)
          hits++;
        prev = v;
      end
      chk(hits, nh[m]);
    end
    // Each channel latches timer_c
    wr(IDX_CTL1, 8'h50);
    wr(IDX_CAP34_CTL, 8'h0a);
    for (int ch = 1; ch < 5; ch++)
    begin
      rdp(ch, v);
      t0 = tc;
      ext_pins_inst.pulse(ch + 1, 3);
      rdp(ch, v);
      chk(16'(v - t0 < tc - t0), 16'h1);
    end
    // Overflow and hold
    ext_pins_inst.pulse(3, 3);
    rd(IDX_CAP_BASE + 6'h2, v8);
    ext_pins_inst.pulse(3, 3);
    rdc(IDX_CTL2, 8'h8c);
    rdc(IDX_CAP_BASE + 6'h2, v8);
    rd(IDX_CAP_BASE + 6'h3, v8);
    rdc(IDX_CTL2, 8'h0c);
    stop_test;
  end
endmodule

bind dual_timer_capture_control dual_timer_sva dual_timer_sva_inst (
  .clk, .rst, .avs_req, .avs_readdata, .avs_waitrequest, .pwm1_level,
  .pwm_out_one_pin_o, .pwm_out_one_pin_oe_n, .pwm_out_two_pin_oe_n,
  .timer_a_value, .timer_b_value, .timer_c_value, .timer_a_irq_flag,
  .timer_b_irq_flag, .timer_c_irq_flag);
`default_nettype wire
